// ---- verilog/stid_tap.sv ----
// test access port with instruction decode and configuration chains
module stid_tap #(
	parameter logic [stid_pkg::ID_W-1:0] ID_VALUE = stid_pkg::ID_DEFAULT // arbitrary value
) (
	input wire logic core_clk, // core clock, 10 MHz
	input wire logic rst_b, // power-on reset, async, active low
	input wire logic clk_en, // clock enable, freezes state when low
	input wire logic tck, // link test clock
	input wire logic tms, // mode select, sampled on tck rise
	input wire logic tdi, // serial data in, sampled on tck rise
	input wire logic [stid_pkg::PAD_W-1:0] pad_in, // pad levels for scan capture
	output logic tdo_q, // serial data out, changes on tck fall
	output logic tdo_oe_b_q, // tdo enable, low while driving
	output stid_pkg::stid_cfg_s cfg_q // configuration in core domain
);
	import stid_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// declarations
	stid_tap_e state_q, state_d;
	logic en_s1_q, en_tck_q;
	logic [PAD_W-1:0] pad_s1_q, pad_s2_q;
	logic [IR_W-1:0] ir_q, ir_sr_q;
	logic [ID_W-1:0] id_sr_q;
	logic byp_q;
	logic upd_tog_q;
	logic tog_s1_q, tog_s2_q, tog_seen_q;
	logic tog_edge;
	logic [3:0] sel_idx;
	logic sel_reserved;
	logic cap_dr, shf_dr, upd_dr, cap_ir, shf_ir, upd_ir;
	logic dr_so;
	logic [N_CHAIN-1:0] so_vec;
	logic [CHAIN_MAX-1:0] upd_all [N_CHAIN];
	logic [CHAIN_MAX-1:0] cap_all [N_CHAIN];

	////////////////////////////////////////////////////////////////////////
	// enable and pad levels into the tck domain
	// first flops feed only the second ones
	always_ff @(posedge tck or negedge rst_b) begin
		if (!rst_b) begin
			en_s1_q <= 1'b0;
			en_tck_q <= 1'b0;
		end else begin
			en_s1_q <= clk_en;
			en_tck_q <= en_s1_q;
		end
	end

	// pads are asynchronous to tck, hence the two stages
	always_ff @(posedge tck or negedge rst_b) begin
		if (!rst_b) begin
			pad_s1_q <= '0;
			pad_s2_q <= '0;
		end else if (en_tck_q) begin
			pad_s1_q <= pad_in;
			pad_s2_q <= pad_s1_q;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// tap state machine
	always_comb begin
		state_d = state_q;
		case (state_q)
			S_RESET: state_d = tms ? S_RESET : S_IDLE; // RL1
			S_IDLE: state_d = tms ? S_SEL_DR : S_IDLE;
			S_SEL_DR: state_d = tms ? S_SEL_IR : S_CAP_DR;
			S_CAP_DR: state_d = tms ? S_EX1_DR : S_SHF_DR;
			S_SHF_DR: state_d = tms ? S_EX1_DR : S_SHF_DR;
			S_EX1_DR: state_d = tms ? S_UPD_DR : S_PAU_DR;
			S_PAU_DR: state_d = tms ? S_EX2_DR : S_PAU_DR;
			S_EX2_DR: state_d = tms ? S_UPD_DR : S_SHF_DR;
			S_UPD_DR: state_d = tms ? S_SEL_DR : S_IDLE;
			S_SEL_IR: state_d = tms ? S_RESET : S_CAP_IR;
			S_CAP_IR: state_d = tms ? S_EX1_IR : S_SHF_IR;
			S_SHF_IR: state_d = tms ? S_EX1_IR : S_SHF_IR;
			S_EX1_IR: state_d = tms ? S_UPD_IR : S_PAU_IR;
			S_PAU_IR: state_d = tms ? S_EX2_IR : S_PAU_IR;
			S_EX2_IR: state_d = tms ? S_UPD_IR : S_SHF_IR;
			S_UPD_IR: state_d = tms ? S_SEL_DR : S_IDLE;
			default: state_d = S_RESET;
		endcase
	end

	// power-on reset puts the port straight into test-logic-reset
	always_ff @(posedge tck or negedge rst_b) begin
		if (!rst_b) begin
			state_q <= S_RESET; // RL2
		end else if (en_tck_q) begin
			state_q <= state_d; // RL1
		end
	end

	assign cap_dr = (state_q == S_CAP_DR);
	assign shf_dr = (state_q == S_SHF_DR);
	assign upd_dr = (state_q == S_UPD_DR);
	assign cap_ir = (state_q == S_CAP_IR);
	assign shf_ir = (state_q == S_SHF_IR);
	assign upd_ir = (state_q == S_UPD_IR);

	////////////////////////////////////////////////////////////////////////
	// instruction register: shift stage and current instruction
	always_ff @(posedge tck or negedge rst_b) begin
		if (!rst_b) begin
			ir_sr_q <= IR_RESET_VAL;
		end else if (en_tck_q) begin
			if (cap_ir) begin
				ir_sr_q <= {ir_q[IR_W-1:2], IR_MARKER}; // RL20
			end else if (shf_ir) begin
				ir_sr_q <= {tdi, ir_sr_q[IR_W-1:1]}; // RL18 RL4
			end
		end
	end

	// test-logic-reset reloads identify so the id chain is live at start
	always_ff @(posedge tck or negedge rst_b) begin
		if (!rst_b) begin
			ir_q <= IR_RESET_VAL; // RL20 RL3
		end else if (en_tck_q) begin
			if (state_q == S_RESET) begin
				ir_q <= IR_RESET_VAL; // RL20
			end else if (upd_ir) begin
				ir_q <= ir_sr_q; // RL4
			end
		end
	end

	// reserved codes have no chain; they fall through to bypass
	assign sel_idx = stid_decode(ir_q); // RL5 RL6 RL7 RL8 RL19
	assign sel_reserved = (ir_q >= RESERVED_CODE_FIRST) && (ir_q <= RESERVED_CODE_LAST); // RL17

	////////////////////////////////////////////////////////////////////////
	// identification and bypass data registers
	always_ff @(posedge tck or negedge rst_b) begin
		if (!rst_b) begin
			id_sr_q <= '0;
		end else if (en_tck_q && sel_idx == SEL_ID) begin
			if (cap_dr) begin
				id_sr_q <= ID_VALUE; // RL21
			end else if (shf_dr) begin
				id_sr_q <= {tdi, id_sr_q[ID_W-1:1]}; // RL18
			end
		end
	end

	// single bypass bit captures zero as the standard asks
	always_ff @(posedge tck or negedge rst_b) begin
		if (!rst_b) begin
			byp_q <= 1'b0;
		end else if (en_tck_q && sel_idx == SEL_BYP) begin
			if (cap_dr) begin
				byp_q <= 1'b0; // RL6
			end else if (shf_dr) begin
				byp_q <= tdi; // RL7 RL19
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// configuration and pad chains, one instance each
	for (genvar g = 0; g < N_CHAIN; g++) begin : g_chain
		localparam int unsigned W = CHAIN_W[g];
		// the pad chain samples pins, the others re-read their own image
		assign cap_all[g] = (g == int'(C_PAD)) ? CHAIN_MAX'(pad_s2_q) : upd_all[g];
		if (W < CHAIN_MAX) begin : g_pad
			assign upd_all[g][CHAIN_MAX-1:W] = '0;
		end
		stid_chain #(.WIDTH(W)) u_chain (
			.tck(tck),
			.rst_b(rst_b),
			.en(en_tck_q),
			.sel(sel_idx == 4'(g)), // RL9 RL10 RL11 RL12 RL13 RL14 RL15 RL16
			.capture(cap_dr),
			.shift(shf_dr),
			.update(upd_dr),
			.tdi(tdi),
			.cap_val(cap_all[g][W-1:0]),
			.so(so_vec[g]),
			.upd_q(upd_all[g][W-1:0])
		);
	end

	////////////////////////////////////////////////////////////////////////
	// serial output mux, launched on the falling edge of tck
	always_comb begin
		dr_so = byp_q;
		if (sel_idx == SEL_ID) begin
			dr_so = id_sr_q[0]; // RL21
		end else if (sel_idx < SEL_ID) begin
			dr_so = so_vec[sel_idx];
		end
	end

	// falling-edge launch gives the master a half period of hold
	always_ff @(negedge tck or negedge rst_b) begin
		if (!rst_b) begin
			tdo_q <= 1'b0;
			tdo_oe_b_q <= 1'b1;
		end else if (en_tck_q) begin
			tdo_q <= shf_ir ? ir_sr_q[0] : dr_so; // RL18
			tdo_oe_b_q <= !(shf_ir || shf_dr); // RL1
		end
	end

	////////////////////////////////////////////////////////////////////////
	// crossing: a toggle marks each update, the core copies the image
	always_ff @(posedge tck or negedge rst_b) begin
		if (!rst_b) begin
			upd_tog_q <= 1'b0;
		end else if (en_tck_q && (upd_dr || upd_ir)) begin
			upd_tog_q <= !upd_tog_q; // RL22
		end
	end

	// two-stage synchroniser for the toggle
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			tog_s1_q <= 1'b0;
			tog_s2_q <= 1'b0;
			tog_seen_q <= 1'b0;
		end else if (clk_en) begin
			tog_s1_q <= upd_tog_q;
			tog_s2_q <= tog_s1_q;
			tog_seen_q <= tog_s2_q;
		end
	end

	assign tog_edge = tog_s2_q ^ tog_seen_q;

	// image is quiet between updates; limitation: updates need 4 core cycles apart
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			cfg_q <= '0;
		end else if (clk_en && tog_edge) begin
			cfg_q.bias_levels <= upd_all[C_BIAS][BIAS_W-1:0]; // RL22
			cfg_q.line_pattern_a_chain <= upd_all[C_LPA][LINE_W-1:0];
			cfg_q.line_pattern_b_chain <= upd_all[C_LPB][LINE_W-1:0];
			cfg_q.discriminator_mask_chain <= upd_all[C_DISC][LINE_W-1:0];
			cfg_q.sequencer_config_chain <= upd_all[C_SEQ][SEQ_W-1:0];
			cfg_q.control_config_chain <= upd_all[C_CTRL][CTRL_W-1:0];
			cfg_q.readout_mode_a <= upd_all[C_RMA][MODE_W-1:0];
			cfg_q.readout_mode_b <= upd_all[C_RMB][MODE_W-1:0];
			cfg_q.pad_scan_chain <= upd_all[C_PAD][PAD_W-1:0];
			cfg_q.pad_override <= (ir_q == PAD_EXTEST_INSTR) || (ir_q == PAD_INTEST_INSTR) ||
				(ir_q == PAD_CLAMP_INSTR); // RL5 RL6
			cfg_q.pad_float <= (ir_q == PAD_FLOAT_INSTR); // RL6
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks in the tck domain, except the image hold check on core_clk
	default clocking tck_cb @(posedge tck);
	endclocking
	default disable iff (!rst_b);

	chk_tms_reset: assert property ((tms && en_tck_q) [*5] |=> state_q == S_RESET) // RL1
		else $error("five tms highs did not reach reset");
	chk_reset_idcode: assert property ((state_q == S_RESET && en_tck_q) |=> // RL20 RL3
		ir_q == IDENTIFY_INSTR)
		else $error("reset state did not load identify");
	chk_ir_marker: assert property ((cap_ir && en_tck_q) |=> // RL20
		ir_sr_q == {$past(ir_q[IR_W-1:2]), IR_MARKER})
		else $error("instruction capture lost marker or instruction");
	chk_ir_lsb_first: assert property ((shf_ir && en_tck_q) |=> // RL18 RL4
		ir_sr_q == {$past(tdi), $past(ir_sr_q[IR_W-1:1])})
		else $error("instruction shift not lsb first");
	chk_pad_codes: assert property ((ir_q == PAD_EXTEST_INSTR || ir_q == PAD_INTEST_INSTR || // RL5
		ir_q == PAD_SAMPLE_INSTR) |-> sel_idx == C_PAD)
		else $error("pad code did not select pad chain");
	chk_bypass_codes: assert property ((ir_q == PAD_FLOAT_INSTR || ir_q == PAD_CLAMP_INSTR || // RL6 RL7
		ir_q == BYPASS_INSTR) |-> sel_idx == SEL_BYP)
		else $error("bypass code did not select bypass");
	chk_reserved_bypass: assert property ((sel_reserved || ir_q == 5'h00 || // RL17 RL19
		(ir_q > PAD_SAMPLE_INSTR && ir_q < IDENTIFY_INSTR)) |-> sel_idx == SEL_BYP)
		else $error("undefined code did not select bypass");
	chk_id_capture: assert property ((ir_q == IDENTIFY_INSTR && cap_dr && en_tck_q) |=> // RL8 RL21
		id_sr_q == ID_VALUE)
		else $error("identification capture wrong");
	// the enable is launched on the fall before this rise, so it is judged in the same cycle
	chk_tdo_drive: assert property ((shf_dr && en_tck_q) |-> !tdo_oe_b_q) // RL1
		else $error("tdo not driven in shift-dr");

	for (genvar c = 0; c < N_CHAIN - 1; c++) begin : g_chk
		chk_chain_code: assert property ((ir_q == CHAIN_CODE[c]) |-> // RL9 RL10 RL11 RL12 RL13 RL14 RL15 RL16
			sel_idx == 4'(c))
			else $error("chain code selected wrong chain");
	end

	chk_cfg_hold: assert property (@(posedge core_clk) disable iff (!rst_b) // RL22
		!(clk_en && tog_edge) |=> $stable(cfg_q))
		else $error("configuration changed without update");

	cov_update_dr: cover property (upd_dr && sel_idx == C_BIAS && en_tck_q);
	cov_update_ir: cover property (upd_ir && en_tck_q);
	cov_id_shift: cover property (shf_dr && sel_idx == SEL_ID && en_tck_q);
	cov_reserved: cover property (sel_reserved && shf_dr);

endmodule : stid_tap

// ---- verilog/stid_pkg.sv ----
// constants, types and decode function for the sensor test access port
// Operation
// RL1 - standard boundary-scan state machine and serial protocol
// RL2 - power-on reset forces Test-Logic-Reset
// RL3 - identification chain selected right after power-on
// RL4 - instruction register is five bits wide
// RL5 - codes 01, 03, 05 select pad chain
// RL6 - codes 02 and 04 select bypass bit
// RL7 - code 1F selects bypass bit
// RL8 - code 0E selects identification chain
// RL9 - code 0F selects bias level chain
// RL10 - code 10 selects line pattern a
// RL11 - code 14 selects line pattern b
// RL12 - code 11 selects discriminator mask chain
// RL13 - code 12 selects sequencer config chain
// RL14 - code 13 selects control config chain
// RL15 - code 1D selects readout mode b
// RL16 - code 1E selects readout mode a
// RL17 - codes 15 to 1C reserved, no register
// RL18 - all registers shift least significant bit first
// RL19 - undefined code selects bypass bit
// RL20 - reset loads identify; capture shows 01 marker
// RL21 - identification chain is 32-bit read-only constant
// RL22 - chains have shift and separate update stage
package stid_pkg;

	////////////////////////////////////////////////////////////////////////
	// instruction codes
	localparam int unsigned IR_W = 5;
	localparam logic [IR_W-1:0] PAD_EXTEST_INSTR = 5'h01;
	localparam logic [IR_W-1:0] PAD_FLOAT_INSTR = 5'h02;
	localparam logic [IR_W-1:0] PAD_INTEST_INSTR = 5'h03;
	localparam logic [IR_W-1:0] PAD_CLAMP_INSTR = 5'h04;
	localparam logic [IR_W-1:0] PAD_SAMPLE_INSTR = 5'h05;
	localparam logic [IR_W-1:0] IDENTIFY_INSTR = 5'h0E;
	localparam logic [IR_W-1:0] BIAS_SELECT_INSTR = 5'h0F;
	localparam logic [IR_W-1:0] LINE_PATTERN_A_INSTR = 5'h10;
	localparam logic [IR_W-1:0] DISCRIMINATOR_MASK_INSTR = 5'h11;
	localparam logic [IR_W-1:0] SEQUENCER_SELECT_INSTR = 5'h12;
	localparam logic [IR_W-1:0] CONTROL_SELECT_INSTR = 5'h13;
	localparam logic [IR_W-1:0] LINE_PATTERN_B_INSTR = 5'h14;
	localparam logic [IR_W-1:0] RESERVED_CODE_FIRST = 5'h15;
	localparam logic [IR_W-1:0] RESERVED_CODE_LAST = 5'h1C;
	localparam logic [IR_W-1:0] READOUT_MODE_B_INSTR = 5'h1D;
	localparam logic [IR_W-1:0] READOUT_MODE_A_INSTR = 5'h1E;
	localparam logic [IR_W-1:0] BYPASS_INSTR = 5'h1F;
	localparam logic [1:0] IR_MARKER = 2'h1;
	localparam logic [IR_W-1:0] IR_RESET_VAL = IDENTIFY_INSTR;

	////////////////////////////////////////////////////////////////////////
	// chain lengths, chain order and select indices
	localparam int unsigned ID_W = 32;
	localparam logic [ID_W-1:0] ID_DEFAULT = 32'h1357_9BDF; // arbitrary value
	localparam int unsigned BIAS_W = 128;
	localparam int unsigned LINE_W = 640;
	localparam int unsigned SEQ_W = 128;
	localparam int unsigned CTRL_W = 40;
	localparam int unsigned MODE_W = 8;
	localparam int unsigned PAD_W = 10;
	localparam int unsigned N_CHAIN = 9;
	localparam int unsigned CHAIN_MAX = 640;
	localparam logic [3:0] C_BIAS = 4'h0;
	localparam logic [3:0] C_LPA = 4'h1;
	localparam logic [3:0] C_DISC = 4'h2;
	localparam logic [3:0] C_SEQ = 4'h3;
	localparam logic [3:0] C_CTRL = 4'h4;
	localparam logic [3:0] C_LPB = 4'h5;
	localparam logic [3:0] C_RMB = 4'h6;
	localparam logic [3:0] C_RMA = 4'h7;
	localparam logic [3:0] C_PAD = 4'h8;
	localparam logic [3:0] SEL_ID = 4'h9;
	localparam logic [3:0] SEL_BYP = 4'hA;
	localparam int unsigned CHAIN_W [N_CHAIN] = '{BIAS_W, LINE_W, LINE_W, SEQ_W, CTRL_W,
		LINE_W, MODE_W, MODE_W, PAD_W};
	localparam logic [IR_W-1:0] CHAIN_CODE [N_CHAIN] = '{BIAS_SELECT_INSTR,
		LINE_PATTERN_A_INSTR, DISCRIMINATOR_MASK_INSTR, SEQUENCER_SELECT_INSTR,
		CONTROL_SELECT_INSTR, LINE_PATTERN_B_INSTR, READOUT_MODE_B_INSTR,
		READOUT_MODE_A_INSTR, PAD_SAMPLE_INSTR};

	////////////////////////////////////////////////////////////////////////
	// tap states, gray coded along the usual path
	typedef enum logic [3:0] {
		S_RESET = 4'h0, S_IDLE = 4'h1, S_SEL_DR = 4'h3, S_CAP_DR = 4'h2,
		S_SHF_DR = 4'h6, S_EX1_DR = 4'h7, S_PAU_DR = 4'h5, S_EX2_DR = 4'h4,
		S_UPD_DR = 4'hC, S_SEL_IR = 4'hD, S_CAP_IR = 4'hF, S_SHF_IR = 4'hE,
		S_EX1_IR = 4'hA, S_PAU_IR = 4'hB, S_EX2_IR = 4'h9, S_UPD_IR = 4'h8
	} stid_tap_e;

	// configuration image handed to the core clock domain
	typedef struct packed {
		logic [BIAS_W-1:0] bias_levels;
		logic [LINE_W-1:0] line_pattern_a_chain;
		logic [LINE_W-1:0] line_pattern_b_chain;
		logic [LINE_W-1:0] discriminator_mask_chain;
		logic [SEQ_W-1:0] sequencer_config_chain;
		logic [CTRL_W-1:0] control_config_chain;
		logic [MODE_W-1:0] readout_mode_a;
		logic [MODE_W-1:0] readout_mode_b;
		logic [PAD_W-1:0] pad_scan_chain;
		logic pad_override;
		logic pad_float;
	} stid_cfg_s;

	// instruction to data path select
	function automatic logic [3:0] stid_decode(input logic [IR_W-1:0] ir);
		logic [3:0] sel;
		sel = SEL_BYP; // undefined and reserved codes land on bypass
		case (ir)
			PAD_EXTEST_INSTR, PAD_INTEST_INSTR, PAD_SAMPLE_INSTR: sel = C_PAD;
			IDENTIFY_INSTR: sel = SEL_ID;
			BIAS_SELECT_INSTR: sel = C_BIAS;
			LINE_PATTERN_A_INSTR: sel = C_LPA;
			DISCRIMINATOR_MASK_INSTR: sel = C_DISC;
			SEQUENCER_SELECT_INSTR: sel = C_SEQ;
			CONTROL_SELECT_INSTR: sel = C_CTRL;
			LINE_PATTERN_B_INSTR: sel = C_LPB;
			READOUT_MODE_B_INSTR: sel = C_RMB;
			READOUT_MODE_A_INSTR: sel = C_RMA;
			default: sel = SEL_BYP;
		endcase
		return sel;
	endfunction : stid_decode

endpackage : stid_pkg

// ---- verilog/stid_chain.sv ----
// one configuration chain: capture/shift stage plus separate update stage
module stid_chain #(
	parameter int unsigned WIDTH = 8
) (
	input wire logic tck, // link clock
	input wire logic rst_b, // async reset, active low
	input wire logic en, // frozen while low
	input wire logic sel, // chain is the active data path
	input wire logic capture, // tap in capture-dr
	input wire logic shift, // tap in shift-dr
	input wire logic update, // tap in update-dr
	input wire logic tdi, // serial input
	input wire logic [WIDTH-1:0] cap_val, // parallel value captured
	output logic so, // serial output, bit 0
	output logic [WIDTH-1:0] upd_q // update stage
);

	logic [WIDTH-1:0] sr_q;

	////////////////////////////////////////////////////////////////////////
	// capture/shift stage; old contents leave while new ones enter
	always_ff @(posedge tck or negedge rst_b) begin
		if (!rst_b) begin
			sr_q <= '0;
		end else if (en && sel) begin
			if (capture) begin
				sr_q <= cap_val; // RL22
			end else if (shift) begin
				sr_q <= {tdi, sr_q[WIDTH-1:1]}; // RL18
			end
		end
	end

	// update stage only moves on update-dr so outputs never ripple
	always_ff @(posedge tck or negedge rst_b) begin
		if (!rst_b) begin
			upd_q <= '0;
		end else if (en && sel && update) begin
			upd_q <= sr_q; // RL22
		end
	end

	assign so = sr_q[0];

endmodule : stid_chain

// ---- testbench/stid_master.sv ----
// boundary-scan master model that drives the link side of the test port
module stid_master (
	output logic tck, // link clock, stands low between frames
	output logic tms, // mode select
	output logic tdi, // serial data into the port
	input wire logic tdo, // serial data from the port
	input wire logic tdo_oe_b // low while the port drives tdo
);
	timeunit 1ns;
	timeprecision 1ns;
	localparam int W = 672;
	logic oe_ok; // every shift cycle saw the port driving
	logic shifting;

	initial begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b1;
		oe_ok = 1'b1;
		shifting = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////
	// one link cycle: change after the fall, sample tdo just before the rise
	task automatic clk(input logic m, input logic d, output logic o);
		tms = m;
		tdi = d;
		#32;
		o = tdo;
		if (shifting && tdo_oe_b !== 1'b0) begin
			oe_ok = 1'b0;
		end
		tck = 1'b1;
		#32;
		tck = 1'b0;
	endtask : clk

	// idle to shift, n bits lsb first, update, back to idle
	task automatic scan(input logic ir, input int n, input logic [W-1:0] din,
		output logic [W-1:0] dout);
		logic o;
		dout = '0;
		clk(1'b1, tdi, o);
		if (ir) begin
			clk(1'b1, tdi, o);
		end
		clk(1'b0, tdi, o);
		clk(1'b0, tdi, o);
		shifting = 1'b1;
		for (int i = 0; i < n; i++) begin
			clk(i == n - 1, din[i], o);
			dout[i] = o;
		end
		shifting = 1'b0;
		clk(1'b1, ~tdi, o);
		clk(1'b0, ~tdi, o);
		tdi = ~tdi; // a released line must not keep a stale level
	endtask : scan

	// eight ones reach test-logic-reset from anywhere, even with a slow enable
	task automatic tlr();
		logic o;
		for (int i = 0; i < 8; i++) begin
			clk(1'b1, tdi, o);
		end
		clk(1'b0, tdi, o);
	endtask : tlr
endmodule : stid_master

// ---- testbench/tb.sv ----
// self-checking bench for the test port instruction decode and chains
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	import stid_pkg::*;
	localparam int W = 672;
	localparam logic [ID_W-1:0] TB_ID = 32'h2468_ACE1; // arbitrary value
	logic core_clk = 1'b0;
	logic rst_b, clk_en, tck, tms, tdi, tdo_q, tdo_oe_b_q;
	logic [PAD_W-1:0] pad_in;
	stid_cfg_s cfg_q;
	int bad_count = 0;
	int n_tests = 0;
	int unsigned seed;
	logic [IR_W-1:0] cur_ir;
	logic [W-1:0] prev [32];
	logic [W-1:0] din, dout, ex, mask;

	always #50 core_clk = ~core_clk;

	stid_tap #(.ID_VALUE(TB_ID)) uut (.core_clk(core_clk), .rst_b(rst_b), .clk_en(clk_en),
		.tck(tck), .tms(tms), .tdi(tdi), .pad_in(pad_in), .tdo_q(tdo_q),
		.tdo_oe_b_q(tdo_oe_b_q), .cfg_q(cfg_q));
	stid_master mst (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo_q), .tdo_oe_b(tdo_oe_b_q));

	////////////////////////////////////////////////////////////////////////
	// path length that each code should put between tdi and tdo
	function automatic int exp_len(input logic [IR_W-1:0] c);
		case (c)
			5'h01, 5'h03, 5'h05: return PAD_W;
			5'h0E: return ID_W;
			5'h0F: return BIAS_W;
			5'h10, 5'h11, 5'h14: return LINE_W;
			5'h12: return SEQ_W;
			5'h13: return CTRL_W;
			5'h1D, 5'h1E: return MODE_W;
			default: return 1;
		endcase
	endfunction : exp_len

	// image field that a code's update stage should land in
	function automatic logic [W-1:0] cfg_field(input logic [IR_W-1:0] c);
		case (c)
			5'h0F: return W'(cfg_q.bias_levels);
			5'h10: return W'(cfg_q.line_pattern_a_chain);
			5'h14: return W'(cfg_q.line_pattern_b_chain);
			5'h11: return W'(cfg_q.discriminator_mask_chain);
			5'h12: return W'(cfg_q.sequencer_config_chain);
			5'h13: return W'(cfg_q.control_config_chain);
			5'h1E: return W'(cfg_q.readout_mode_a);
			5'h1D: return W'(cfg_q.readout_mode_b);
			default: return W'(cfg_q.pad_scan_chain);
		endcase
	endfunction : cfg_field

	task automatic check(input logic [W-1:0] seen, input logic [W-1:0] exp);
		n_tests++;
		if (seen !== exp) begin
			bad_count++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : end_of_test

	////////////////////////////////////////////////////////////////////////
	// optional ir load, then a data scan longer than the path by 16 bits
	task automatic do_code(input logic [IR_W-1:0] c, input logic ir);
		int len;
		@(negedge core_clk);
		pad_in = PAD_W'($urandom);
		repeat (6) @(negedge core_clk); // six core cycles with tck idle; the pad synchroniser only fills on the tck rises of the scans
		if (ir) begin
			mst.scan(1'b1, IR_W, W'(c), dout);
			check(dout, W'({cur_ir[4:2], 2'b01}));
			cur_ir = c;
			repeat (8) @(posedge core_clk);
			check(W'({cfg_q.pad_override, cfg_q.pad_float}),
				W'({c == 5'h01 || c == 5'h03 || c == 5'h04, c == 5'h02}));
		end
		len = exp_len(c);
		for (int i = 0; i < W; i += 32) begin
			din[i +: 32] = $urandom;
		end
		mask = (W'(1) << len) - W'(1);
		case (len)
			1: ex = '0;
			ID_W: ex = W'(TB_ID);
			PAD_W: ex = W'(pad_in);
			default: ex = prev[c];
		endcase
		ex = (ex & mask) | (din << len);
		mst.scan(1'b0, len + 16, din, dout);
		check(dout, ex & ((mask << 16) | W'(16'hFFFF)));
		repeat (2) @(posedge core_clk);
		check(W'({mst.oe_ok, tdo_oe_b_q}), W'(2'b11));
		if (len > 1 && c != 5'h0E) begin
			prev[c] = (din >> 16) & mask;
			repeat (8) @(posedge core_clk);
			check(cfg_field(c), prev[c]);
		end
	endtask : do_code

	// watchdog, several times the expected half millisecond of scans
	initial begin
		#3ms;
		bad_count++;
		end_of_test();
	end

	initial begin
		seed = $urandom(3);
		rst_b = 1'b0;
		clk_en = 1'b1;
		pad_in = '0;
		for (int c = 0; c < 32; c++) begin
			prev[c] = '0;
		end
		repeat (12) @(negedge core_clk);
		rst_b = 1'b1;
		mst.tlr();
		cur_ir = IDENTIFY_INSTR;
		do_code(IDENTIFY_INSTR, 1'b0);
		// every code twice, so chains shift out what the first pass wrote
		for (int p = 0; p < 2; p++) begin
			for (int c = 0; c < 32; c++) begin
				do_code(5'(c), 1'b1);
			end
		end
		// a frozen port must ignore a data scan after its first two link cycles, which still pass the enable synchroniser
		do_code(READOUT_MODE_A_INSTR, 1'b1);
		@(negedge core_clk);
		clk_en = 1'b0;
		repeat (4) @(negedge core_clk);
		mst.scan(1'b0, MODE_W, ~prev[5'h1E], dout);
		@(negedge core_clk);
		clk_en = 1'b1;
		repeat (4) @(negedge core_clk);
		mst.tlr();
		mst.oe_ok = 1'b1; // frozen shift cycles are not judged
		repeat (8) @(posedge core_clk);
		check(cfg_field(5'h1E), prev[5'h1E]);
		cur_ir = IDENTIFY_INSTR;
		do_code(IDENTIFY_INSTR, 1'b0);
		end_of_test();
	end
endmodule : tb
